// File: arc_drive_if.sv
/*
 * arc_drive_if: ratings and overdrive path between the register bank
 * and the drive limiter. assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface arc_drive_if;
	logic [7:0] nominal;
	logic [7:0] absolute;
	logic       accel_en;
	logic [7:0] od_request;
	logic [7:0] full_scale;
	logic [7:0] od_limited;

	modport cfg (
		output nominal,
		output absolute,
		output accel_en,
		output od_request,
		input  full_scale,
		input  od_limited
	);
	modport lim (
		input  nominal,
		input  absolute,
		input  accel_en,
		input  od_request,
		output full_scale,
		output od_limited
	);
endinterface

// File: arc_drive_limit.sv
/*
 * arc_drive_limit: picks waveform full scale and clamps overdrive.
 * assumes ratings come from the register bank on the same clock.
 */
`timescale 1ns/100ps
module arc_drive_limit
	import arc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// ratings and overdrive
	arc_drive_if.lim lim
);

	// ************************************************************
	// full scale selection
	// ************************************************************
	logic [7:0] full_scale_reg;
	logic [7:0] od_limited_reg;

	// nominal rating with acceleration, absolute rating without
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			full_scale_reg <= RST_NOMINAL;
		else if (lim.accel_en)
			full_scale_reg <= lim.nominal;
		else
			full_scale_reg <= lim.absolute;
	end

	// clamp only applies while acceleration overdrives the actuator
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			od_limited_reg <= 8'h00;
		else if (lim.accel_en && lim.od_request > lim.absolute)
			od_limited_reg <= lim.absolute;
		else
			od_limited_reg <= lim.od_request;
	end

	assign lim.full_scale = full_scale_reg;
	assign lim.od_limited = od_limited_reg;

	// ************************************************************
	// checks
	// ************************************************************
	property p_fs_select;
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> full_scale_reg ==
			($past(lim.accel_en) ? $past(lim.nominal) : $past(lim.absolute));
	endproperty
	a_fs_select: assert property (p_fs_select)
		else $error("full scale does not follow acceleration setting");

	property p_od_clamp;
		@(posedge clk) disable iff (!rst_b)
		lim.accel_en |=> od_limited_reg <= $past(lim.absolute);
	endproperty
	a_od_clamp: assert property (p_od_clamp)
		else $error("overdrive exceeds absolute rating");

	property p_od_pass;
		@(posedge clk) disable iff (!rst_b)
		!lim.accel_en |=> od_limited_reg == $past(lim.od_request);
	endproperty
	a_od_pass: assert property (p_od_pass)
		else $error("overdrive clamped without acceleration");

endmodule

// File: arc_pkg.sv
/*
 * arc_pkg: constants shared by the actuator rating register bank.
 * assumes a single 20 MHz clock domain and byte-wide register access.
 */
package arc_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_PERIOD_LOW   = 8'h0B;
	localparam logic [7:0] OFS_NOMINAL      = 8'h0C;
	localparam logic [7:0] OFS_ABSOLUTE     = 8'h0D;
	localparam logic [7:0] OFS_CURRENT      = 8'h0E;
	localparam logic [7:0] OFS_V2I_HIGH     = 8'h0F;
	localparam logic [7:0] OFS_V2I_LOW      = 8'h10;
	localparam logic [7:0] OFS_IMP_HIGH     = 8'h11;
	localparam logic [7:0] OFS_IMP_LOW      = 8'h12;
	localparam logic [7:0] OFS_TOP_CFG      = 8'h13;

	// ************************************************************
	// field widths and positions
	// ************************************************************
	localparam int PERIOD_LOW_W = 7;
	localparam int PERIOD_W     = 15;
	localparam int CURRENT_W    = 5;
	localparam int IMP_LOW_W    = 2;
	localparam int IMP_W        = 10;
	localparam int ACCEL_BIT    = 2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [6:0] RST_PERIOD_LOW = 7'h4F;
	localparam logic [7:0] RST_NOMINAL    = 8'h5A;
	localparam logic [7:0] RST_ABSOLUTE   = 8'h78;
	localparam logic [4:0] RST_CURRENT    = 5'h17;
	localparam logic [7:0] RST_V2I_HIGH   = 8'h01;
	localparam logic [7:0] RST_V2I_LOW    = 8'h0D;
	localparam logic [7:0] RST_IMP_HIGH   = 8'h00;
	localparam logic [1:0] RST_IMP_LOW    = 2'h0;
	localparam logic       RST_ACCEL      = 1'b1;

	// ************************************************************
	// scaling (for software and documentation of units)
	// ************************************************************
	localparam real PERIOD_UNIT_NS   = 1333.32;
	localparam real VOLT_STEP_MV     = 23.4;
	localparam real CUR_OFFSET_MA    = 28.6;
	localparam real CUR_STEP_MA      = 7.2;
	localparam real V2I_DIVISOR      = 1.6104;
	localparam real IMP_STEP_MOHM    = 62.5;

endpackage

// File: arc_rating_regs.sv
/*
 * arc_rating_regs: actuator rating and calibration register bank.
 * assumes a byte register port on the same clock as the drive loop;
 * the period high byte and impedance values come from nearby logic.
 */
`timescale 1ns/100ps
module arc_rating_regs
	import arc_pkg::*;
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	// drive loop inputs
	input  wire logic [7:0]           resonant_period_high_bits,
	input  wire logic [7:0]           od_request,
	input  wire logic                 impedance_load,
	input  wire logic [7:0]           impedance_high_in,
	input  wire logic [IMP_LOW_W-1:0] impedance_low_in,
	// drive loop outputs
	output logic [PERIOD_W-1:0]       resonant_period,
	output logic [7:0]                full_scale,
	output logic [7:0]                overdrive_limited,
	output logic [CURRENT_W-1:0]      current_rating_code,
	output logic [15:0]               translation_factor,
	output logic [IMP_W-1:0]          calc_impedance,
	output logic                      accel_enable
);

	// ************************************************************
	// decode helper
	// ************************************************************
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = reg_wr && (reg_addr == ofs);
	endfunction

	// ************************************************************
	// writable registers
	// ************************************************************
	logic [PERIOD_LOW_W-1:0] resonant_period_low_reg;
	logic [7:0]              nominal_voltage_rating_reg;
	logic [7:0]              absolute_voltage_rating_reg;
	logic [CURRENT_W-1:0]    max_current_rating_reg;
	logic [7:0]              volt_to_current_high_reg;
	logic [7:0]              volt_to_current_low_reg;
	logic                    accel_en_reg;

	// period low field, bit 7 is not stored
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			resonant_period_low_reg <= RST_PERIOD_LOW;
		else if (wr_hit(OFS_PERIOD_LOW))
			resonant_period_low_reg <= reg_wdata[PERIOD_LOW_W-1:0];
	end

	// voltage ratings in 23.4 mV steps
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			nominal_voltage_rating_reg  <= RST_NOMINAL;
			absolute_voltage_rating_reg <= RST_ABSOLUTE;
		end
		else if (wr_hit(OFS_NOMINAL))
			nominal_voltage_rating_reg <= reg_wdata;
		else if (wr_hit(OFS_ABSOLUTE))
			absolute_voltage_rating_reg <= reg_wdata;
	end

	// current code keeps only its five low bits
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			max_current_rating_reg <= RST_CURRENT;
		else if (wr_hit(OFS_CURRENT))
			max_current_rating_reg <= reg_wdata[CURRENT_W-1:0];
	end

	// translation factor bytes, written independently
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			volt_to_current_high_reg <= RST_V2I_HIGH;
			volt_to_current_low_reg  <= RST_V2I_LOW;
		end
		else if (wr_hit(OFS_V2I_HIGH))
			volt_to_current_high_reg <= reg_wdata;
		else if (wr_hit(OFS_V2I_LOW))
			volt_to_current_low_reg <= reg_wdata;
	end

	// acceleration enable, the only bit of its word held here
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			accel_en_reg <= RST_ACCEL;
		else if (wr_hit(OFS_TOP_CFG))
			accel_en_reg <= reg_wdata[ACCEL_BIT];
	end

	// ************************************************************
	// read-only impedance result
	// ************************************************************
	logic [7:0]           measured_impedance_high_reg;
	logic [IMP_LOW_W-1:0] impedance_low_reg;

	// host writes never reach these; only the estimator loads them
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			measured_impedance_high_reg <= RST_IMP_HIGH;
			impedance_low_reg           <= RST_IMP_LOW;
		end
		else if (impedance_load)
		begin
			measured_impedance_high_reg <= impedance_high_in;
			impedance_low_reg           <= impedance_low_in;
		end
	end

	// ************************************************************
	// register read port
	// ************************************************************
	logic [7:0] rdata_next;

	// unmapped offsets read as zero, narrow fields zero-extended
	always_comb
	begin
		if (reg_addr == OFS_PERIOD_LOW)
			rdata_next = {1'b0, resonant_period_low_reg};
		else if (reg_addr == OFS_NOMINAL)
			rdata_next = nominal_voltage_rating_reg;
		else if (reg_addr == OFS_ABSOLUTE)
			rdata_next = absolute_voltage_rating_reg;
		else if (reg_addr == OFS_CURRENT)
			rdata_next = {3'h0, max_current_rating_reg};
		else if (reg_addr == OFS_V2I_HIGH)
			rdata_next = volt_to_current_high_reg;
		else if (reg_addr == OFS_V2I_LOW)
			rdata_next = volt_to_current_low_reg;
		else if (reg_addr == OFS_IMP_HIGH)
			rdata_next = measured_impedance_high_reg;
		else if (reg_addr == OFS_IMP_LOW)
			rdata_next = {6'h00, impedance_low_reg};
		else if (reg_addr == OFS_TOP_CFG)
			rdata_next = 8'(accel_en_reg) << ACCEL_BIT;
		else
			rdata_next = 8'h00;
	end

	// read data holds until the next read strobe
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_next;
	end

	// ************************************************************
	// drive loop values
	// ************************************************************
	// registered one cycle behind the stored fields; a pair written a byte at a time is seen half-written in between
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			resonant_period    <= '0;
			translation_factor <= 16'h0000;
			calc_impedance     <= '0;
		end
		else
		begin
			resonant_period <= {resonant_period_high_bits,
				resonant_period_low_reg};
			translation_factor <= {volt_to_current_high_reg,
				volt_to_current_low_reg};
			calc_impedance <= {measured_impedance_high_reg,
				impedance_low_reg};
		end
	end

	assign current_rating_code = max_current_rating_reg;
	assign accel_enable        = accel_en_reg;

	// ************************************************************
	// full scale and overdrive limiter
	// ************************************************************
	arc_drive_if drv ();

	assign drv.nominal    = nominal_voltage_rating_reg;
	assign drv.absolute   = absolute_voltage_rating_reg;
	assign drv.accel_en   = accel_en_reg;
	assign drv.od_request = od_request;
	assign full_scale        = drv.full_scale;
	assign overdrive_limited = drv.od_limited;

	arc_drive_limit u_limit (
		.clk   (clk),
		.rst_b (rst_b),
		.lim   (drv.lim)
	);

	// ************************************************************
	// checks
	// ************************************************************
	// gated by the sampled reset so the release edge starts no attempt
	property p_period_concat;
		@(posedge clk) disable iff (!rst_b)
		rst_b |=> resonant_period == {$past(resonant_period_high_bits),
			$past(resonant_period_low_reg)};
	endproperty
	a_period_concat: assert property (p_period_concat)
		else $error("period is not high byte times 128 plus low");

	property p_period_wr;
		@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == OFS_PERIOD_LOW |=> ##1
			resonant_period[PERIOD_LOW_W-1:0] ==
			$past(reg_wdata[PERIOD_LOW_W-1:0], 2);
	endproperty
	a_period_wr: assert property (p_period_wr)
		else $error("period low write not seen by drive loop");

	property p_nominal_wr;
		@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == OFS_NOMINAL && accel_en_reg
			|=> ##1 full_scale == $past(reg_wdata, 2);
	endproperty
	a_nominal_wr: assert property (p_nominal_wr)
		else $error("nominal write did not set full scale");

	property p_abs_rd;
		@(posedge clk) disable iff (!rst_b)
		(reg_wr && reg_addr == OFS_ABSOLUTE)
			##1 (reg_rd && reg_addr == OFS_ABSOLUTE)
			|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_abs_rd: assert property (p_abs_rd)
		else $error("absolute rating readback wrong");

	property p_current_rd;
		@(posedge clk) disable iff (!rst_b)
		reg_rd && reg_addr == OFS_CURRENT |=> reg_rdata[7:5] == 3'h0
			&& reg_rdata[4:0] == $past(max_current_rating_reg);
	endproperty
	a_current_rd: assert property (p_current_rd)
		else $error("current code readback wrong");

	property p_v2i_bytes;
		@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == OFS_V2I_LOW |=> ##1
			translation_factor[7:0] == $past(reg_wdata, 2);
	endproperty
	a_v2i_bytes: assert property (p_v2i_bytes)
		else $error("translation factor low byte wrong");

	property p_imp_ro;
		@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == OFS_IMP_HIGH && !impedance_load
			|=> $stable(measured_impedance_high_reg);
	endproperty
	a_imp_ro: assert property (p_imp_ro)
		else $error("host write changed impedance result");

	property p_accel_wr;
		@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == OFS_TOP_CFG
			|=> accel_enable == $past(reg_wdata[ACCEL_BIT]);
	endproperty
	a_accel_wr: assert property (p_accel_wr)
		else $error("acceleration enable write lost");

endmodule

// File: arc_rating_regs_bench.sv
/*
 * arc_rating_regs_bench: self-checking bench for the actuator rating
 * register bank. assumes the byte register port with one-cycle write
 * and read strobes, registered read data and 1 cycle derived lag.
 */
`timescale 1ns/100ps
module arc_rating_regs_bench;
	import arc_pkg::*;

	// ************************************************************
	// signals
	// ************************************************************
	logic                 clk;
	logic                 rst_b;
	logic [7:0]           reg_addr;
	logic [7:0]           reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [7:0]           reg_rdata;
	logic [7:0]           resonant_period_high_bits;
	logic [7:0]           od_request;
	logic                 impedance_load;
	logic [7:0]           impedance_high_in;
	logic [IMP_LOW_W-1:0] impedance_low_in;
	logic [PERIOD_W-1:0]  resonant_period;
	logic [7:0]           full_scale;
	logic [7:0]           overdrive_limited;
	logic [CURRENT_W-1:0] current_rating_code;
	logic [15:0]          translation_factor;
	logic [IMP_W-1:0]     calc_impedance;
	logic                 accel_enable;
	int                   n_mismatch;
	int                   total_checks;

`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
		end \
	end

	// ************************************************************
	// design under test
	// ************************************************************
	arc_rating_regs dut (
		.clk                       (clk),
		.rst_b                     (rst_b),
		.reg_addr                  (reg_addr),
		.reg_wdata                 (reg_wdata),
		.reg_wr                    (reg_wr),
		.reg_rd                    (reg_rd),
		.reg_rdata                 (reg_rdata),
		.resonant_period_high_bits (resonant_period_high_bits),
		.od_request                (od_request),
		.impedance_load            (impedance_load),
		.impedance_high_in         (impedance_high_in),
		.impedance_low_in          (impedance_low_in),
		.resonant_period           (resonant_period),
		.full_scale                (full_scale),
		.overdrive_limited         (overdrive_limited),
		.current_rating_code       (current_rating_code),
		.translation_factor        (translation_factor),
		.calc_impedance            (calc_impedance),
		.accel_enable              (accel_enable)
	);

	// 20 MHz clock
	always #25 clk = ~clk;

	// ************************************************************
	// tasks
	// ************************************************************
	// let n edges pass, then step off the edge so outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// one-cycle write strobe; strobe drops at the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// one-cycle read strobe, data looked at after the taking edge
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// overdrive request is a level; result lags one register stage
	task automatic set_od(input logic [7:0] v);
		@(posedge clk);
		od_request <= v;
		tick(2);
	endtask

	task automatic finish_test;
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		clk                       = 1'b0;
		rst_b                     = 1'b0;
		reg_addr                  = 8'h00;
		reg_wdata                 = 8'h00;
		reg_wr                    = 1'b0;
		reg_rd                    = 1'b0;
		resonant_period_high_bits = 8'h21;
		od_request                = 8'h00;
		impedance_load            = 1'b0;
		impedance_high_in         = 8'h00;
		impedance_low_in          = 2'h0;
		n_mismatch                = 0;
		total_checks              = 0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(current_rating_code, 5'h17);
		`CHK(accel_enable, 1'b1);
		@(posedge clk);
		rst_b <= 1'b1;
		tick(2);
		// reset contents through the register port
		rd_chk(OFS_PERIOD_LOW, 8'h4F);
		rd_chk(OFS_NOMINAL, 8'h5A);
		rd_chk(OFS_ABSOLUTE, 8'h78);
		rd_chk(OFS_CURRENT, 8'h17);
		rd_chk(OFS_V2I_HIGH, 8'h01);
		rd_chk(OFS_V2I_LOW, 8'h0D);
		rd_chk(OFS_IMP_HIGH, 8'h00);
		rd_chk(OFS_TOP_CFG, 8'h04);
		`CHK(resonant_period, {8'h21, 7'h4F});
		`CHK(translation_factor, 16'h010D);
		`CHK(full_scale, 8'h5A);
		// impedance result loads together and cannot be written
		@(posedge clk);
		impedance_load    <= 1'b1;
		impedance_high_in <= 8'hA5;
		impedance_low_in  <= 2'h3;
		@(posedge clk);
		impedance_load    <= 1'b0;
		impedance_high_in <= 8'h5A;
		impedance_low_in  <= 2'h0;
		tick(2);
		`CHK(calc_impedance, 10'h297);
		wr(OFS_IMP_HIGH, 8'h00);
		rd_chk(OFS_IMP_HIGH, 8'hA5);
		rd_chk(OFS_IMP_LOW, 8'h03);
		// clamp with acceleration on, default ratings
		set_od(8'hFF);
		`CHK(overdrive_limited, 8'h78);
		set_od(8'h78);
		`CHK(overdrive_limited, 8'h78);
		set_od(8'h40);
		`CHK(overdrive_limited, 8'h40);
		// acceleration off: absolute sets full scale, no clamp
		set_od(8'hFF);
		wr(OFS_TOP_CFG, 8'hFB);
		tick(2);
		`CHK(accel_enable, 1'b0);
		`CHK(full_scale, 8'h78);
		`CHK(overdrive_limited, 8'hFF);
		rd_chk(OFS_TOP_CFG, 8'h00);
		wr(OFS_TOP_CFG, 8'h04);
		tick(2);
		`CHK(full_scale, 8'h5A);
		// new ratings, unused bits must read back zero
		wr(OFS_PERIOD_LOW, 8'hD3);
		wr(OFS_NOMINAL, 8'h5C);
		wr(OFS_ABSOLUTE, 8'h9E);
		wr(OFS_CURRENT, 8'hF6);
		wr(OFS_V2I_HIGH, 8'h3B);
		wr(OFS_V2I_LOW, 8'hC7);
		wr(8'h20, 8'h55);
		rd_chk(OFS_PERIOD_LOW, 8'h53);
		rd_chk(OFS_NOMINAL, 8'h5C);
		rd_chk(OFS_ABSOLUTE, 8'h9E);
		rd_chk(OFS_CURRENT, 8'h16);
		rd_chk(OFS_V2I_HIGH, 8'h3B);
		rd_chk(OFS_V2I_LOW, 8'hC7);
		rd_chk(8'h20, 8'h00);
		`CHK(current_rating_code, 5'h16);
		`CHK(translation_factor, 16'h3BC7);
		`CHK(full_scale, 8'h5C);
		`CHK(overdrive_limited, 8'h9E);
		`CHK(resonant_period, {8'h21, 7'h53});
		// high byte from the neighbour joins the stored low bits
		@(posedge clk);
		resonant_period_high_bits <= 8'hFF;
		tick(2);
		`CHK(resonant_period, 15'h7FD3);
		// write then read back on the very next edge
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= OFS_ABSOLUTE;
		reg_wdata <= 8'hA1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, 8'hA1);
		finish_test();
	end

	// hang guard: whole sequence needs well under 400 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
endmodule
